// File: fsp_flash_protect.v
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`include "fsp_defs.vh"

module fsp_flash_protect #(
    parameter SIZE_KB = 8'd60,
    parameter PROG_CYCLES = `FSP_PROG_TIME_NS / `FSP_CLK_PERIOD_NS,
    parameter ERASE_CYCLES = `FSP_ERASE_TIME_NS / `FSP_CLK_PERIOD_NS
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire incircuit_comm_mode,
    input wire incircuit_programming_mode,
    input wire tool_inserted,
    input wire tool_attached,
    input wire ext_read_req,
    input wire [15:0] ext_read_addr,
    input wire [7:0] flash_rdata,
    output reg [7:0] ext_read_data,
    output reg ext_read_blocked,
    output reg flash_prog,
    output reg flash_sector_erase,
    output reg flash_mass_erase,
    output reg [15:0] flash_addr,
    output reg [7:0] flash_wdata,
    output reg readout_protect_option_bit,
    output reg app_serial_pins_en
);
    localparam ST_IDLE = 3'd0;
    localparam ST_PROG = 3'd1;
    localparam ST_SERASE = 3'd2;
    localparam ST_MERASE = 3'd3;
    localparam ST_PURGE = 3'd4;
    localparam ST_OPT = 3'd5;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [7:0] ctrl;
    reg [7:0] option_byte;
    reg [7:0] pend_option;
    reg [15:0] op_addr;
    reg [7:0] op_data;
    reg [1:0] guard;
    reg rej_sect;
    reg rej_rop;
    reg tool_mode;
    reg timer_start;
    reg [15:0] timer_cycles;
    wire timer_busy;
    wire timer_done;
    wire [1:0] sector;
    wire present;
    wire allowed;

    function [7:0] fsp_status;
        input [2:0] st;
        input rs;
        input rr;
        input rop;
        input armed;
        input tm;
        begin
            fsp_status = 8'h00;
            fsp_status[`FSP_STAT_BUSY] = (st != ST_IDLE);
            fsp_status[`FSP_STAT_REJ_SECT] = rs;
            fsp_status[`FSP_STAT_REJ_ROP] = rr;
            fsp_status[`FSP_STAT_ROP] = rop;
            fsp_status[`FSP_STAT_ARMED] = armed;
            fsp_status[`FSP_STAT_PURGE] = (st == ST_PURGE);
            fsp_status[`FSP_STAT_TOOL] = tm;
        end
    endfunction

    fsp_sector_check #(
        .SIZE_KB(SIZE_KB)
    ) u_check (
        .addr(op_addr),
        .tool_mode(tool_mode),
        .sector(sector),
        .present(present),
        .allowed(allowed)
    );

    fsp_op_timer #(
        .WIDTH(16)
    ) u_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(timer_start),
        .cycles(timer_cycles),
        .busy(timer_busy),
        .done(timer_done)
    );

    wire ctrl_wr = reg_wr && (reg_addr == `FSP_ADDR_CTRL);
    wire guard_open = (guard == 2'd2);
    wire rop_on = option_byte[`FSP_OPT_ROP_BIT];
    // protection drops only when the new option clears the bit
    wire rop_removal = rop_on && !pend_option[`FSP_OPT_ROP_BIT];

    always @* begin
        tool_mode = tool_inserted || incircuit_programming_mode ||
            incircuit_comm_mode;
    end

    // request decode: a command only counts on a guarded write
    always @* begin
        next_state = ST_IDLE;
        if (ctrl_wr && guard_open) begin
            if (reg_wdata[`FSP_CTRL_OPTWR] && tool_mode) begin
                next_state = rop_removal ? ST_PURGE : ST_OPT;
            end else if (rop_on) begin
                next_state = ST_IDLE;
            end else if (reg_wdata[`FSP_CTRL_MERASE] && tool_mode) begin
                next_state = ST_MERASE;
            end else if (reg_wdata[`FSP_CTRL_SERASE] && allowed) begin
                next_state = ST_SERASE;
            end else if (reg_wdata[`FSP_CTRL_PROG] && allowed) begin
                next_state = ST_PROG;
            end
        end
    end

    wire cmd_any = |reg_wdata[3:0];
    wire rej_rop_ev = ctrl_wr && guard_open && cmd_any && rop_on &&
        !(reg_wdata[`FSP_CTRL_OPTWR] && tool_mode);
    wire rej_sect_ev = ctrl_wr && guard_open && cmd_any && !rop_on &&
        (next_state == ST_IDLE);

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            ctrl <= `FSP_CTRL_RESET;
            option_byte <= `FSP_OPT_RESET;
            pend_option <= `FSP_OPT_RESET;
            op_addr <= 16'h0000;
            op_data <= 8'h00;
            guard <= 2'd0;
            rej_sect <= 1'b0;
            rej_rop <= 1'b0;
            timer_start <= 1'b0;
            timer_cycles <= 16'h0000;
            reg_rdata <= 8'h00;
            ext_read_data <= 8'h00;
            ext_read_blocked <= 1'b0;
            flash_prog <= 1'b0;
            flash_sector_erase <= 1'b0;
            flash_mass_erase <= 1'b0;
            flash_addr <= 16'h0000;
            flash_wdata <= 8'h00;
            readout_protect_option_bit <= 1'b0;
            app_serial_pins_en <= 1'b1;
        end else if (clk_en) begin
            timer_start <= 1'b0;
            flash_prog <= 1'b0;
            flash_sector_erase <= 1'b0;
            flash_mass_erase <= 1'b0;
            readout_protect_option_bit <= option_byte[`FSP_OPT_ROP_BIT];
            app_serial_pins_en <= !tool_attached;

            if (reg_wr && state == ST_IDLE) begin
                case (reg_addr)
                    `FSP_ADDR_ADDRL: op_addr[7:0] <= reg_wdata;
                    `FSP_ADDR_ADDRH: op_addr[15:8] <= reg_wdata;
                    `FSP_ADDR_DATA: op_data <= reg_wdata;
                    `FSP_ADDR_OPTION: pend_option <= reg_wdata;
                    default: ;
                endcase
            end

            // two-key sequence; a wrong guard write or a control write re-locks
            if (reg_wr && reg_addr == `FSP_ADDR_GUARD) begin
                if (guard == 2'd0 && reg_wdata == `FSP_KEY1) begin
                    guard <= 2'd1;
                end else if (guard == 2'd1 && reg_wdata == `FSP_KEY2) begin
                    guard <= 2'd2;
                end else begin
                    guard <= 2'd0;
                end
            end else if (ctrl_wr) begin
                guard <= 2'd0;
            end

            // sticky reject flags: a new reject wins over a clear
            if (rej_sect_ev) begin
                rej_sect <= 1'b1;
            end else if (ctrl_wr) begin
                rej_sect <= 1'b0;
            end
            if (rej_rop_ev) begin
                rej_rop <= 1'b1;
            end else if (ctrl_wr) begin
                rej_rop <= 1'b0;
            end

            case (state)
                ST_IDLE: begin
                    if (ctrl_wr && guard_open && next_state != ST_IDLE) begin
                        state <= next_state;
                        ctrl <= {4'h0, reg_wdata[3:0]};
                        timer_start <= 1'b1;
                        timer_cycles <= (next_state == ST_PROG) ?
                            PROG_CYCLES[15:0] : ERASE_CYCLES[15:0];
                        flash_addr <= op_addr;
                        flash_wdata <= op_data;
                        flash_prog <= (next_state == ST_PROG);
                        flash_sector_erase <= (next_state == ST_SERASE);
                        flash_mass_erase <= (next_state == ST_MERASE) ||
                            (next_state == ST_PURGE);
                    end
                end
                ST_PURGE: begin
                    // option is updated only after the array is blank
                    if (timer_done) begin
                        option_byte <= pend_option;
                        state <= ST_IDLE;
                        ctrl <= `FSP_CTRL_RESET;
                    end
                end
                ST_OPT: begin
                    if (timer_done) begin
                        option_byte <= pend_option;
                        state <= ST_IDLE;
                        ctrl <= `FSP_CTRL_RESET;
                    end
                end
                ST_PROG, ST_SERASE, ST_MERASE: begin
                    if (timer_done) begin
                        state <= ST_IDLE;
                        ctrl <= `FSP_CTRL_RESET;
                    end
                end
                default: state <= ST_IDLE;
            endcase

            if (reg_rd) begin
                case (reg_addr)
                    `FSP_ADDR_CTRL: reg_rdata <= ctrl;
                    `FSP_ADDR_STAT: reg_rdata <= fsp_status(state, rej_sect, rej_rop,
                        rop_on, guard_open, tool_mode);
                    `FSP_ADDR_ADDRL: reg_rdata <= op_addr[7:0];
                    `FSP_ADDR_ADDRH: reg_rdata <= op_addr[15:8];
                    `FSP_ADDR_DATA: reg_rdata <= op_data;
                    `FSP_ADDR_OPTION: reg_rdata <= option_byte;
                    default: reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end

            // external dumps see zeros while protection holds
            if (ext_read_req) begin
                ext_read_blocked <= rop_on;
                ext_read_data <= rop_on ? 8'h00 : flash_rdata;
            end else begin
                ext_read_blocked <= 1'b0;
                ext_read_data <= 8'h00;
            end
        end
    end
endmodule // fsp_flash_protect

// File: fsp_defs.vh
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// register offsets (byte addresses on the plain register port)
`define FSP_ADDR_CTRL 8'h00
`define FSP_ADDR_STAT 8'h01
`define FSP_ADDR_GUARD 8'h02
`define FSP_ADDR_ADDRL 8'h03
`define FSP_ADDR_ADDRH 8'h04
`define FSP_ADDR_DATA 8'h05
`define FSP_ADDR_OPTION 8'h06

// control register (flash_program_control_status) fields
`define FSP_CTRL_RESET 8'h00
`define FSP_CTRL_PROG 0
`define FSP_CTRL_SERASE 1
`define FSP_CTRL_MERASE 2
`define FSP_CTRL_OPTWR 3

// status register fields
`define FSP_STAT_BUSY 0
`define FSP_STAT_REJ_SECT 1
`define FSP_STAT_REJ_ROP 2
`define FSP_STAT_ROP 3
`define FSP_STAT_ARMED 4
`define FSP_STAT_PURGE 5
`define FSP_STAT_TOOL 6

// guard unlock keys, written in this order
`define FSP_KEY1 8'h56
`define FSP_KEY2 8'hae

// option byte
`define FSP_OPT_ROP_BIT 0
`define FSP_OPT_RESET 8'h00

// sector map: 4 Kbyte sectors at the top of the 64K space
`define FSP_SECT0_BASE 4'hf
`define FSP_SECT1_BASE 4'he

// flash sizes in Kbytes
`define FSP_SIZE_4K 8'd4
`define FSP_SIZE_8K 8'd8

// operation times
`define FSP_PROG_TIME_NS 10000
`define FSP_ERASE_TIME_NS 40000
`define FSP_CLK_PERIOD_NS 5

`endif

// File: fsp_sector_check.v
`timescale 1ns/10ps
module fsp_sector_check #(
    parameter SIZE_KB = 8'd60
) (
    input wire [15:0] addr,
    input wire tool_mode,
    output reg [1:0] sector,
    output reg present,
    output reg allowed
);
`include "fsp_defs.vh"
    always @* begin
        if (addr[15:12] == `FSP_SECT0_BASE) begin
            sector = 2'd0;
        end else if (addr[15:12] == `FSP_SECT1_BASE) begin
            sector = 2'd1;
        end else begin
            sector = 2'd2;
        end
        // sector 2 spans the rest of the array below e000
        case (sector)
            2'd0: present = 1'b1;
            2'd1: present = (SIZE_KB >= `FSP_SIZE_8K);
            default: present = (SIZE_KB > `FSP_SIZE_8K) &&
                ({4'h0, addr[15:12]} >= (8'd16 - {2'b00, SIZE_KB[7:2]}));
        endcase
        allowed = present && (tool_mode || (sector != 2'd0));
    end
endmodule // fsp_sector_check

// File: fsp_op_timer.v
`timescale 1ns/10ps
module fsp_op_timer #(
    parameter WIDTH = 16
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire start,
    input wire [WIDTH-1:0] cycles,
    output reg busy,
    output reg done
);
    reg [WIDTH-1:0] count;
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= {WIDTH{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            if (start && !busy) begin
                count <= cycles;
                busy <= 1'b1;
            end else if (busy) begin
                if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // fsp_op_timer

// File: fsp_flash_protect_properties.sv
`timescale 1ns/10ps
module fsp_flash_protect_properties #(
    parameter SIZE_KB = 8'd60
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire clk_en,
    input wire incircuit_comm_mode,
    input wire incircuit_programming_mode,
    input wire tool_inserted,
    input wire tool_attached,
    input wire ext_read_req,
    input wire [7:0] ext_read_data,
    input wire ext_read_blocked,
    input wire flash_prog,
    input wire flash_sector_erase,
    input wire flash_mass_erase,
    input wire [15:0] flash_addr,
    input wire readout_protect_option_bit,
    input wire app_serial_pins_en
);
    localparam int LOW = 65536 - SIZE_KB * 1024;
    wire tool = incircuit_comm_mode | incircuit_programming_mode | tool_inserted;
    wire wr_op = flash_prog | flash_sector_erase;
    reg purged;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // each new protection needs its own purge before removal
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            purged <= 1'b0;
        end else if (flash_mass_erase) begin
            purged <= 1'b1;
        end else if ($rose(readout_protect_option_bit)) begin
            purged <= 1'b0;
        end
    end
    prog_single_a: assert property (flash_prog && clk_en |=> !flash_prog)
        else $error("program pulse too long");
    sect0_guard_a: assert property (wr_op && flash_addr[15:12] == 4'hf |->
        tool || $past(tool))
        else $error("top sector written outside tool mode");
    size_range_a: assert property (wr_op |-> flash_addr >= LOW)
        else $error("operation on absent sector");
    rop_noprog_a: assert property (wr_op |-> !readout_protect_option_bit)
        else $error("write while protected");
    rop_read_a: assert property (ext_read_req && clk_en |=>
        ext_read_blocked == readout_protect_option_bit &&
        (!ext_read_blocked || ext_read_data == 8'h00))
        else $error("external read not guarded");
    purge_first_a: assert property ($fell(readout_protect_option_bit) |-> purged)
        else $error("protection removed without purge");
    merase_tool_a: assert property (flash_mass_erase |-> tool)
        else $error("mass erase outside tool mode");
    serial_pins_a: assert property (clk_en && !sys_rst |=>
        app_serial_pins_en == !$past(tool_attached))
        else $error("serial pins not released");
endmodule // fsp_flash_protect_properties

bind fsp_flash_protect fsp_flash_protect_properties #(.SIZE_KB(SIZE_KB)) u_props (
    .sys_clk, .sys_rst, .clk_en, .incircuit_comm_mode, .incircuit_programming_mode,
    .tool_inserted, .tool_attached, .ext_read_req, .ext_read_data, .ext_read_blocked,
    .flash_prog, .flash_sector_erase, .flash_mass_erase, .flash_addr,
    .readout_protect_option_bit, .app_serial_pins_en
);

// File: fsp_flash_model.sv
`timescale 1ns/10ps
module fsp_flash_model (
    input wire sys_clk,
    input wire flash_prog,
    input wire flash_sector_erase,
    input wire flash_mass_erase,
    input wire [15:0] flash_addr,
    input wire [7:0] flash_wdata,
    input wire [15:0] ext_read_addr,
    output wire [7:0] flash_rdata
);
    reg [7:0] mem [0:65535];
    integer i;
    integer j;
    assign flash_rdata = mem[ext_read_addr];
    initial begin
        for (j = 0; j < 65536; j = j + 1) mem[j] = 8'h3c;
    end
    always @(posedge sys_clk) begin
        // a cell can only lose bits when programmed
        if (flash_prog) mem[flash_addr] <= mem[flash_addr] & flash_wdata;
        if (flash_sector_erase) begin
            for (i = 0; i < 4096; i = i + 1) begin
                mem[{flash_addr[15:12], i[11:0]}] <= 8'hff;
            end
        end
        if (flash_mass_erase) begin
            for (i = 0; i < 65536; i = i + 1) mem[i] <= 8'hff;
        end
    end
endmodule // fsp_flash_model

// File: flash_sector_protection_tb_top.sv
`timescale 1ns/10ps
`include "fsp_defs.vh"
module flash_sector_protection_tb_top;
    reg sys_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg clk_en = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg incircuit_comm_mode = 1'b0;
    reg incircuit_programming_mode = 1'b0;
    reg tool_inserted = 1'b0;
    reg tool_attached = 1'b0;
    reg ext_read_req = 1'b0;
    reg [15:0] ext_read_addr = 16'h0000;
    wire [7:0] reg_rdata, ext_read_data, flash_rdata, flash_wdata;
    wire [15:0] flash_addr;
    wire ext_read_blocked, flash_prog, flash_sector_erase, flash_mass_erase;
    wire readout_protect_option_bit, app_serial_pins_en;
    integer num_errors = 0;
    integer n_tests = 0;
    integer n_prog = 0;
    integer n_serase = 0;
    integer n_merase = 0;
    integer i;
    reg [7:0] v;

    fsp_flash_protect #(.SIZE_KB(8'd8), .PROG_CYCLES(4), .ERASE_CYCLES(4)) i_dut (
        .sys_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .incircuit_comm_mode, .incircuit_programming_mode, .tool_inserted, .tool_attached,
        .ext_read_req, .ext_read_addr, .flash_rdata, .ext_read_data, .ext_read_blocked,
        .flash_prog, .flash_sector_erase, .flash_mass_erase, .flash_addr, .flash_wdata,
        .readout_protect_option_bit, .app_serial_pins_en);
    fsp_flash_model i_flash (.sys_clk, .flash_prog, .flash_sector_erase, .flash_mass_erase,
        .flash_addr, .flash_wdata, .ext_read_addr, .flash_rdata);

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (flash_prog) n_prog <= n_prog + 1;
        if (flash_sector_erase) n_serase <= n_serase + 1;
        if (flash_mass_erase) n_merase <= n_merase + 1;
    end

    task chk(input [15:0] got, input [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        v = reg_rdata;
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        rd(a);
        chk(v, e);
    endtask
    task setaddr(input [15:0] a, input [7:0] d);
        wr(`FSP_ADDR_ADDRL, a[7:0]);
        wr(`FSP_ADDR_ADDRH, a[15:8]);
        wr(`FSP_ADDR_DATA, d);
    endtask
    task cmd(input [7:0] c);
        integer k;
        wr(`FSP_ADDR_GUARD, `FSP_KEY1);
        wr(`FSP_ADDR_GUARD, `FSP_KEY2);
        wr(`FSP_ADDR_CTRL, c);
        v = 8'h01;
        for (k = 0; k < 100 && v[0] !== 1'b0; k = k + 1) rd(`FSP_ADDR_STAT);
        chk(v[0], 1'b0);
    endtask
    task xrd(input [15:0] a, input [7:0] ed, input eb);
        @(posedge sys_clk);
        ext_read_addr <= a;
        ext_read_req <= 1'b1;
        @(posedge sys_clk);
        ext_read_req <= 1'b0;
        @(negedge sys_clk);
        chk(ext_read_data, ed);
        chk(ext_read_blocked, eb);
    endtask
    task stop_test;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task t_guard;
        setaddr(16'he010, 8'ha5);
        wr(`FSP_ADDR_CTRL, 8'h01);
        wr(`FSP_ADDR_GUARD, `FSP_KEY1);
        wr(`FSP_ADDR_GUARD, 8'h00);
        wr(`FSP_ADDR_CTRL, 8'h01);
        repeat (10) @(posedge sys_clk);
        chk(n_prog[15:0], 16'd0);
        cmd(8'h01);
        chk(n_prog[15:0], 16'd1);
        xrd(16'he010, 8'h24, 1'b0);
        $display("guard test done");
    endtask
    task t_iap;
        setaddr(16'hf010, 8'ha5);
        cmd(8'h01);
        rd(`FSP_ADDR_STAT);
        chk(v & 8'h07, 8'h02);
        setaddr(16'hd000, 8'h00);
        cmd(8'h02);
        chk(n_serase[15:0], 16'd0);
        setaddr(16'he000, 8'h00);
        cmd(8'h02);
        chk(n_serase[15:0], 16'd1);
        xrd(16'he010, 8'hff, 1'b0);
        xrd(16'hf010, 8'h3c, 1'b0);
        $display("application mode test done");
    endtask
    task t_tool;
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge sys_clk);
            // comm mode stays up while programming mode joins it
            {tool_inserted, incircuit_programming_mode, incircuit_comm_mode} <=
                3'h1 << i | {1'b0, i == 1, i == 1};
            setaddr(16'hf020 + i[15:0], 8'ha5);
            cmd(8'h01);
            chk(n_prog[15:0], 16'd2 + i[15:0]);
            xrd(16'hf020 + i[15:0], 8'h24, 1'b0);
        end
        cmd(8'h04);
        chk(n_merase[15:0], 16'd1);
        xrd(16'hf020, 8'hff, 1'b0);
        $display("tool mode test done");
    endtask
    task t_rop;
        // a programmed byte that only the purge can wipe
        setaddr(16'he040, 8'h5a);
        cmd(8'h01);
        xrd(16'he040, 8'h5a, 1'b0);
        wr(`FSP_ADDR_OPTION, 8'h01);
        cmd(8'h08);
        chk(readout_protect_option_bit, 1'b1);
        rdc(`FSP_ADDR_OPTION, 8'h01);
        xrd(16'he010, 8'h00, 1'b1);
        setaddr(16'he030, 8'ha5);
        cmd(8'h01);
        chk(n_prog[15:0], 16'd5);
        rd(`FSP_ADDR_STAT);
        chk(v & 8'h07, 8'h04);
        wr(`FSP_ADDR_OPTION, 8'h00);
        cmd(8'h08);
        chk(n_merase[15:0], 16'd2);
        chk(readout_protect_option_bit, 1'b0);
        xrd(16'he030, 8'hff, 1'b0);
        xrd(16'he040, 8'hff, 1'b0);
        $display("protection test done");
    endtask
    task t_pins;
        @(posedge sys_clk);
        clk_en <= 1'b0;
        tool_attached <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(app_serial_pins_en, 1'b1);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(app_serial_pins_en, 1'b0);
        // reset cuts a running program and the control register reads back its reset value
        wr(`FSP_ADDR_GUARD, `FSP_KEY1);
        wr(`FSP_ADDR_GUARD, `FSP_KEY2);
        wr(`FSP_ADDR_CTRL, 8'h01);
        rdc(`FSP_ADDR_CTRL, 8'h01);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        tool_attached <= 1'b0;
        rdc(`FSP_ADDR_CTRL, `FSP_CTRL_RESET);
        rdc(8'h20, 8'h00);
        chk(app_serial_pins_en, 1'b1);
        $display("serial pin test done");
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdc(`FSP_ADDR_CTRL, 8'h00);
        t_guard;
        t_iap;
        t_tool;
        t_rop;
        t_pins;
        stop_test;
    end
    // the sequence needs a few hundred cycles; this leaves ample margin
    initial begin
        #100000;
        num_errors = num_errors + 1;
        stop_test;
    end
endmodule // flash_sector_protection_tb_top
